// ### hdl/ccs_period_tick.sv
// output period tick generator
// assumes clk domain; period is a module parameter
`default_nettype none
module ccs_period_tick #(
  parameter int PERIOD = ccs_pkg::CCS_OUT_PER_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // restart and tick
  input  wire logic restart,
  output logic      tick
);
  import ccs_pkg::*;
  logic [CCS_CNT_W-1:0] cnt_q;
  // count output periods, one-cycle tick at the end of each
  always_ff @(posedge clk) begin
    if (!rstn || restart) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (cnt_q == CCS_CNT_W'(PERIOD - 1)) begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### hdl/ccs_sequencer.sv
// calibration completion sequencer: mode bits, ready level held until the next nonzero command taken while idle, result
// assumes mode writes and conversion data come from logic on clk
//
// What this block does
// [R01] at the end of any calibration the ready output is driven low.
// [R02] when ready falls the data register holds a fresh conversion.
// [R03] the mode bits return to 0,0 once a calibration completes.
// [R04] mode bits clear before ready falls and imply no fresh data.
// [R05] mode clear ends the calibration; ready adds a conversion and delay.
// [R06] the pipeline delay never exceeds 2000 master clock periods.
// [R07] the host watches ready or polls the mode bits for completion.
// [R08] code 0,1 is self calibration: clear at 6 periods, ready at 9.
// [R09] code 1,0 is zero-scale system cal: clear at 3, ready at 4.
// [R10] code 1,1 is full-scale system cal: clear at 3, ready at 4.
// [R11] the host writes a nonzero code and waits for completion.
`default_nettype none
module ccs_sequencer #(
  parameter int OUT_PER = ccs_pkg::CCS_OUT_PER_CYC,
  parameter int MCLK_DIV = 2,
  parameter int TP_MCLK = ccs_pkg::CCS_TP_DEF_MCLK
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // mode command from the serial port
  input  wire logic             mode_wr,
  input  wire ccs_pkg::ccs_mode_t mode_wdata,
  // conversion result from the filter
  input  wire logic [15:0]      conv_data,
  // status toward the serial port and pin
  output logic                  op_mode_bit_hi,
  output logic                  op_mode_bit_lo,
  output logic                  result_ready_n,
  output logic [15:0]           data_out,
  output logic                  cal_active
);
  import ccs_pkg::*;

  localparam int TP_CYC = TP_MCLK * MCLK_DIV;
  localparam int TP_MAX_CYC = CCS_TP_MAX_MCLK * MCLK_DIV;
  // a longer request is cut to the limit so the delay stays in bounds
  localparam int TP_USE = (TP_CYC > TP_MAX_CYC) ? TP_MAX_CYC : TP_CYC;
  // expected cycles from the accept edge, used by the timing checks
  localparam int SELF_CLR_CYC = CCS_SELF_CAL_PER * OUT_PER + 1;
  localparam int SYS_CLR_CYC  = CCS_SYS_CAL_PER * OUT_PER + 1;
  localparam int SELF_RDY_CYC = CCS_SELF_RDY_PER * OUT_PER + TP_USE + 1;
  localparam int SYS_RDY_CYC  = CCS_SYS_RDY_PER * OUT_PER + TP_USE + 1;

  typedef enum logic [2:0] {
    CCS_IDLE, CCS_CAL, CCS_CONV, CCS_PIPE
  } ccs_state_t;

  ccs_state_t           state_q;
  logic [3:0]           per_q;
  logic [3:0]           conv_per_q;
  logic [CCS_CNT_W-1:0] tp_q;
  logic                 tick;
  logic                 start;
  logic [CCS_CNT_W-1:0] run_cyc_q;
  logic [CCS_CNT_W-1:0] pipe_cyc_q;
  logic                 self_q;

  // calibration commands only taken while idle
  assign start = mode_wr && (mode_wdata != CCS_MD_NORMAL) &&
                 (state_q == CCS_IDLE);

  ccs_period_tick #(.PERIOD(OUT_PER)) u_tick (
    .clk     (clk),
    .rstn    (rstn),
    .restart (start),
    .tick    (tick)
  );

  // calibration and ready lengths per code
  function automatic logic [3:0] cal_len(input ccs_mode_t m);
    cal_len = (m == CCS_MD_SELFCAL) ? 4'(CCS_SELF_CAL_PER)
                                    : 4'(CCS_SYS_CAL_PER);
  endfunction
  function automatic logic [3:0] rdy_len(input ccs_mode_t m);
    rdy_len = (m == CCS_MD_SELFCAL) ? 4'(CCS_SELF_RDY_PER)
                                    : 4'(CCS_SYS_RDY_PER);
  endfunction

  // sequence state machine
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q    <= CCS_IDLE;
      per_q      <= '0;
      conv_per_q <= '0;
      tp_q       <= '0;
    end else begin
      case (state_q)
        CCS_IDLE: if (start) begin
          state_q    <= CCS_CAL;
          per_q      <= cal_len(mode_wdata);   // [R08] [R09] [R10]
          conv_per_q <= rdy_len(mode_wdata) - cal_len(mode_wdata);
        end
        CCS_CAL: if (tick) begin
          if (per_q == 4'h1) begin
            state_q <= CCS_CONV;               // [R05]
            per_q   <= conv_per_q;
          end else begin
            per_q <= per_q - 4'h1;
          end
        end
        CCS_CONV: if (tick) begin
          if (per_q == 4'h1) begin
            state_q <= CCS_PIPE;
            tp_q    <= CCS_CNT_W'(TP_USE - 1); // [R06]
          end else begin
            per_q <= per_q - 4'h1;
          end
        end
        CCS_PIPE: begin
          if (tp_q == '0) state_q <= CCS_IDLE;
          else tp_q <= tp_q - 1'b1;
        end
        default: state_q <= CCS_IDLE;
      endcase
    end
  end

  // mode bits: set by command, cleared when calibration ends
  always_ff @(posedge clk) begin
    if (!rstn) begin
      op_mode_bit_hi <= 1'b0;
      op_mode_bit_lo <= 1'b0;
    end else if (start) begin
      op_mode_bit_hi <= mode_wdata[1];
      op_mode_bit_lo <= mode_wdata[0];
    end else if (state_q == CCS_CAL && tick && per_q == 4'h1) begin
      op_mode_bit_hi <= 1'b0;                  // [R03] [R04]
      op_mode_bit_lo <= 1'b0;
    end
  end

  // ready goes high at command, low with the fresh conversion result
  always_ff @(posedge clk) begin
    if (!rstn) begin
      result_ready_n <= 1'b1;
      data_out       <= CCS_DATA_RST;
    end else if (start) begin
      result_ready_n <= 1'b1;
    end else if (state_q == CCS_PIPE && tp_q == '0) begin
      result_ready_n <= 1'b0;                  // [R01]
      data_out       <= conv_data;             // [R02]
    end
  end

  // busy flag from calibration start to ready
  always_ff @(posedge clk) begin
    if (!rstn) cal_active <= 1'b0;
    else if (start) cal_active <= 1'b1;
    else if (state_q == CCS_PIPE && tp_q == '0) cal_active <= 1'b0;
  end

  // cycles since the accept edge, for the timing checks
  always_ff @(posedge clk) begin
    if (!rstn || start) run_cyc_q <= '0;
    else if (cal_active) run_cyc_q <= run_cyc_q + 1'b1;
  end

  // cycles spent in the delay phase, for the delay limit check
  always_ff @(posedge clk) begin
    if (!rstn || state_q != CCS_PIPE) pipe_cyc_q <= '0;
    else pipe_cyc_q <= pipe_cyc_q + 1'b1;
  end

  // kind of calibration running, for the timing checks
  always_ff @(posedge clk) begin
    if (!rstn) self_q <= 1'b0;
    else if (start) self_q <= (mode_wdata == CCS_MD_SELFCAL);
  end

  // assertions
  rdy_order_a: assert property (@(posedge clk) disable iff (!rstn) // [R04]
    $fell(result_ready_n) |-> !op_mode_bit_hi && !op_mode_bit_lo)
    else $error("ready fell while mode bits set");
  mode_clear_a: assert property (@(posedge clk) disable iff (!rstn) // [R03]
    $fell(cal_active) |-> {op_mode_bit_hi, op_mode_bit_lo} == 2'h0)
    else $error("mode bits not clear at end");
  rdy_fall_a: assert property (@(posedge clk) disable iff (!rstn) // [R01]
    $fell(cal_active) |-> !result_ready_n)
    else $error("ready not low at end of calibration");
  data_load_a: assert property (@(posedge clk) disable iff (!rstn) // [R02]
    $fell(result_ready_n) |-> data_out == $past(conv_data))
    else $error("data not loaded with ready");
  pipe_max_a: assert property (@(posedge clk) disable iff (!rstn) // [R06]
    state_q == CCS_PIPE |-> pipe_cyc_q < CCS_CNT_W'(TP_MAX_CYC))
    else $error("pipeline delay too long");
  pipe_len_a: assert property (@(posedge clk) disable iff (!rstn) // [R05]
    $rose(state_q == CCS_PIPE) |->
      ({op_mode_bit_hi, op_mode_bit_lo} == 2'h0) && result_ready_n)
    else $error("pipeline phase wrong");
  mode_set_a: assert property (@(posedge clk) disable iff (!rstn) // [R08]
    start |=> {op_mode_bit_hi, op_mode_bit_lo} == $past(mode_wdata))
    else $error("mode bits not loaded");
  busy_rdy_a: assert property (@(posedge clk) disable iff (!rstn) // [R05]
    cal_active && state_q != CCS_IDLE |-> result_ready_n)
    else $error("ready low during calibration");
  clear_time_a: assert property (@(posedge clk) disable iff (!rstn) // [R05]
    $fell(op_mode_bit_hi || op_mode_bit_lo) |->
      run_cyc_q == (self_q ? CCS_CNT_W'(SELF_CLR_CYC)
                           : CCS_CNT_W'(SYS_CLR_CYC)))
    else $error("mode bits cleared at wrong time");
  rdy_time_a: assert property (@(posedge clk) disable iff (!rstn) // [R05]
    $fell(result_ready_n) |->
      run_cyc_q == (self_q ? CCS_CNT_W'(SELF_RDY_CYC)
                           : CCS_CNT_W'(SYS_RDY_CYC)))
    else $error("ready fell at wrong time");
  cal_mode_a: assert property (@(posedge clk) disable iff (!rstn) // [R04]
    state_q == CCS_CAL |-> {op_mode_bit_hi, op_mode_bit_lo} != 2'h0)
    else $error("mode bits cleared during calibration");
  self_cov: cover property (@(posedge clk) disable iff (!rstn)
    start && mode_wdata == CCS_MD_SELFCAL);
  zs_cov: cover property (@(posedge clk) disable iff (!rstn)
    start && mode_wdata == CCS_MD_ZSCAL);
  fs_cov: cover property (@(posedge clk) disable iff (!rstn)
    start && mode_wdata == CCS_MD_FSCAL);
  done_cov: cover property (@(posedge clk) disable iff (!rstn)
    $fell(result_ready_n));
  busy_cov: cover property (@(posedge clk) disable iff (!rstn)
    mode_wr && mode_wdata != CCS_MD_NORMAL && state_q != CCS_IDLE);
endmodule
`default_nettype wire

// ### shared/ccs_pkg.sv
// constants and types for the calibration completion sequencer
// assumes a single 200 MHz clock and synchronous active-low reset
`default_nettype none
package ccs_pkg;
  // operating-mode codes held in the two mode bits
  typedef enum logic [1:0] {
    CCS_MD_NORMAL  = 2'h0,
    CCS_MD_SELFCAL = 2'h1,
    CCS_MD_ZSCAL   = 2'h2,
    CCS_MD_FSCAL   = 2'h3
  } ccs_mode_t;
  // calibration lengths in output periods
  localparam int CCS_SELF_CAL_PER = 6;
  localparam int CCS_SELF_RDY_PER = 9;
  localparam int CCS_SYS_CAL_PER  = 3;
  localparam int CCS_SYS_RDY_PER  = 4;
  // pipeline delay limit in master clock periods
  localparam int CCS_TP_MAX_MCLK  = 2000;
  // default pipeline delay used, in master clock periods
  localparam int CCS_TP_DEF_MCLK  = 1000;
  // default output period in system clock cycles
  localparam int CCS_OUT_PER_CYC  = 64;
  localparam int CCS_CNT_W        = 16;
  localparam logic [15:0] CCS_DATA_RST = 16'h0000;
endpackage
`default_nettype wire

// ### verif/ccs_host_model.sv
// host model: writes mode codes and times both completion signs
// assumes the same clock as the sequencer
`default_nettype none
module ccs_host_model (
  // clock
  input  wire logic         clk,
  // command to the sequencer
  output logic              mode_wr,
  output ccs_pkg::ccs_mode_t mode_wdata,
  // status from the sequencer
  input  wire logic         op_mode_bit_hi,
  input  wire logic         op_mode_bit_lo,
  input  wire logic         result_ready_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import ccs_pkg::*;
  initial mode_wr = 1'b0;
  initial mode_wdata = CCS_MD_NORMAL;
  // one-cycle write, then data no longer holds the code
  task automatic send(input ccs_mode_t code);
    @(posedge clk);
    mode_wr    <= 1'b1;
    mode_wdata <= code;
    @(posedge clk);
    mode_wr    <= 1'b0;
    mode_wdata <= ccs_mode_t'(~code);
  endtask
  // poll both signs, cycles counted from the accept edge
  task automatic watch(output int tc, output int tr,
                       output logic [2:0] f);
    int n;
    n = 0;
    tc = -1;
    tr = -1;
    #1;
    f = {op_mode_bit_hi, op_mode_bit_lo, result_ready_n};
    while (tr < 0 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
      if (tc < 0 && {op_mode_bit_hi, op_mode_bit_lo} == 2'h0) tc = n;
      if (result_ready_n == 1'b0) tr = n;
    end
  endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
// testbench: each mode code, busy refusal, code zero refusal
// assumes short output period and pipeline delay parameters
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ccs_pkg::*;
  localparam int OP  = 8;
  localparam int TPC = 8;
  logic        clk, rstn, wr, hi, lo, rdy_n, busy;
  ccs_mode_t   wdata;
  logic [15:0] conv_data, data_out;
  int          fail_count, tests_run, cycles;
  ccs_sequencer #(.OUT_PER(OP), .MCLK_DIV(2), .TP_MCLK(4)) dut (
    .clk(clk), .rstn(rstn), .mode_wr(wr), .mode_wdata(wdata),
    .conv_data(conv_data), .op_mode_bit_hi(hi), .op_mode_bit_lo(lo),
    .result_ready_n(rdy_n), .data_out(data_out), .cal_active(busy));
  ccs_host_model host (
    .clk(clk), .mode_wr(wr), .mode_wdata(wdata), .op_mode_bit_hi(hi),
    .op_mode_bit_lo(lo), .result_ready_n(rdy_n));
  // clock and hang limit
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, exp, input string s);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic chk_win(input int got, lo_b, hi_b, input string s);
    tests_run++;
    if (got < lo_b || got > hi_b) begin
      fail_count++;
      $display("MISMATCH %0t %s at %0d", $time, s, got);
    end
  endtask
  task automatic reset_case();
    #1;
    chk({12'h0, hi, lo, rdy_n, busy}, 16'h0002, "reset state");
    chk(data_out, CCS_DATA_RST, "reset data");
  endtask
  task automatic cal_case(input ccs_mode_t code, input int c, r,
                          input logic [15:0] d);
    int tc, tr;
    logic [2:0] f;
    @(posedge clk) conv_data <= d;
    host.send(code);
    host.watch(tc, tr, f);
    chk({13'h0, f}, {13'h0, code, 1'b1}, "mode on accept");
    chk_win(tc, c * OP - 1, c * OP + 2, "mode clear");
    chk_win(tc, 1, tr - 1, "clear before ready");
    chk_win(tr, r * OP + TPC, r * OP + TPC + 3, "ready fall");
    chk(data_out, d, "fresh data");
    chk({15'h0, busy}, 16'h0000, "busy end");
  endtask
  task automatic busy_case();
    int tc, tr;
    logic [2:0] f;
    @(posedge clk) conv_data <= 16'h5A5A;
    host.send(CCS_MD_ZSCAL);
    repeat (4) @(posedge clk);
    #1;
    chk({15'h0, busy}, 16'h0001, "busy flag");
    host.send(CCS_MD_SELFCAL);
    host.watch(tc, tr, f);
    chk({13'h0, f}, 16'h0005, "busy write");
    chk_win(tr, 4 * OP + TPC - 6, 4 * OP + TPC - 3, "first cal ready");
    chk(data_out, 16'h5A5A, "busy data");
    host.send(CCS_MD_NORMAL);
    repeat (3) @(posedge clk);
    #1;
    chk({13'h0, hi, lo, rdy_n}, 16'h0000, "code zero");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // main sequence
  initial begin
    rstn = 1'b0;
    conv_data = 16'h0;
    fail_count = 0;
    tests_run = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    reset_case();
    @(posedge clk) rstn <= 1'b1;
    cal_case(CCS_MD_SELFCAL, 6, 9, 16'hA5C3);
    cal_case(CCS_MD_ZSCAL, 3, 4, 16'h1E2D);
    cal_case(CCS_MD_FSCAL, 3, 4, 16'hF00F);
    busy_case();
    complete_run();
  end
endmodule
`default_nettype wire
